// ===== rtl/mpp_pkg.sv
// constants, register map and encodings for the port pin logic
package mpp_pkg;
  localparam int NUM_PORTS = 8;
  localparam int PORT_W = 8;
  localparam int ADR_W = 12;
  localparam int PORT_B_IDX = 1;
  localparam int PORT_I_IDX = 7;

  // general ports A,B,C,D,F,G,H,I sit at index*16
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_DIR = 4'h4;
  localparam logic [3:0] OFS_PULL = 4'h8;
  localparam logic [ADR_W-1:0] ADDR_PORTE_DATA = 12'h080;
  localparam logic [ADR_W-1:0] ADDR_PORTE_PULL = 12'h084;
  localparam logic [ADR_W-1:0] ADDR_OUT_SEL = 12'h090;
  localparam logic [ADR_W-1:0] ADDR_AN_SEL = 12'h094;
  localparam logic [ADR_W-1:0] ADDR_OSC_CTRL = 12'h098;
  localparam logic [ADR_W-1:0] ADDR_STATUS = 12'h09c;

  // output selection register fields
  localparam int SEL_SERIAL_CLOCK_PIN_CH0_BIT = 0;
  localparam int SEL_SO0_BIT = 1;
  localparam int SEL_SCK1_BIT = 2;
  localparam int SEL_SO1_BIT = 3;
  localparam int SEL_PWM_BIT = 4;
  localparam int SEL_TO_LSB = 5;
  // oscillator control fields
  localparam int OSC_STOP_BIT = 0;
  localparam int OSC_SUBSTOP_BIT = 1;

  // port B pins that carry serial channel outputs
  localparam int SERIAL_CLOCK_PIN_CH0_PIN = 2;
  localparam int SO0_PIN = 4;
  localparam int SCK1_PIN = 5;
  localparam int SO1_PIN = 7;

  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [1:0] PULL_RST = 2'h0;
  localparam logic [1:0] PORTE_OUT_RST = 2'h3;
  localparam logic PORTE_PULL_RST = 1'b0;
  localparam logic [1:0] SERIAL_SEL_RST = 2'h0;
  localparam logic PWM_SEL_RST = 1'b0;
  localparam logic [7:0] AN_SEL_RST = 8'h00;

  // clock-adjust divider taps on the 32 kHz count: /2 and /16
  localparam int ADJ_CNT_W = 4;
  localparam int ADJ_FAST_BIT = 0;
  localparam int ADJ_SLOW_BIT = 3;

  typedef enum logic [1:0] {
    MPP_TO_PORT,
    MPP_TO_TIMER,
    MPP_TO_ADJ_FAST,
    MPP_TO_ADJ_SLOW
  } mpp_tosel_t;
endpackage

// ===== rtl/mpp_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module mpp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_chk
    $error("mpp_sync needs WIDTH of at least 1");
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// ===== rtl/mpp_port_pins.sv
// port pin control: direction, pull-ups, output muxing, analog select, oscillator pins
`timescale 1ns/1ps
module mpp_port_pins (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0][7:0] portPinIn,
  output logic [7:0][7:0] portPinOut,
  output logic [7:0][7:0] portPinOeN,
  output logic [7:0][7:0] portPullEn,
  input wire logic [3:0] portEPinIn,
  output logic portEPullEn,
  output logic pwmPinOut,
  output logic timerAdjPinOut,
  output logic [3:0] portELevel,
  output logic [7:0] portBLevel,
  output logic [7:0] analogMuxSel,
  input wire logic [1:0] serialSckOut,
  input wire logic [1:0] serialSckOe,
  input wire logic [1:0] serialDataOut,
  input wire logic [1:0] serialDataOe,
  input wire logic pwmIn,
  input wire logic timerMatch,
  output logic [3:0] extIrqLevel,
  input wire logic stopExitReq,
  output logic mainOscFeedbackEn,
  output logic mainCrystalOutHigh,
  input wire logic subclockInPinIn,
  output logic subclockInPinOut,
  output logic subclockInPinOeN,
  output logic subclockOutHigh,
  output logic subOscFeedbackEn,
  output logic subclockTick,
  output logic clockAdjustFast,
  output logic clockAdjustSlow
);
  localparam int NP = mpp_pkg::NUM_PORTS;
  localparam int SYNC_W = NP * mpp_pkg::PORT_W + 5;

  // pin input synchronisation
  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinSync;
  logic [7:0][7:0] portLevel;
  logic subLevel;

  assign pinRaw = {subclockInPinIn, portEPinIn, portPinIn};

  mpp_sync #(.WIDTH(SYNC_W)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(pinRaw),
    .dout(pinSync)
  );

  assign portLevel = pinSync[NP*8-1:0];
  assign portELevel = pinSync[NP*8+3:NP*8];
  assign subLevel = pinSync[NP*8+4];
  assign portBLevel = portLevel[mpp_pkg::PORT_B_IDX];
  assign extIrqLevel = portLevel[mpp_pkg::PORT_I_IDX][3:0];

  // wishbone decode
  logic req;
  logic wrFire;
  logic isPortArea;
  logic [2:0] portIdx;
  logic [3:0] regOfs;
  logic ack;
  logic next_ack;
  logic [31:0] rdData;
  logic [31:0] next_rdData;
  logic [31:0] rdMux;

  assign req = wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master sees ack
  assign wrFire = req & wb_we_i & ack & wb_sel_i[0];
  assign isPortArea = wb_adr_i < mpp_pkg::ADDR_PORTE_DATA;
  assign portIdx = wb_adr_i[6:4];
  assign regOfs = wb_adr_i[3:0];

  // control state shared with the readback
  wire [7:0][7:0] portDataW;
  wire [7:0][7:0] portDirW;
  wire [7:0][1:0] portPullW;

  logic [1:0] portEData;
  logic [1:0] next_portEData;
  logic portEPull;
  logic next_portEPull;
  logic [1:0] sckSel;
  logic [1:0] next_sckSel;
  logic [1:0] soSel;
  logic [1:0] next_soSel;
  logic pwmSel;
  logic next_pwmSel;
  mpp_pkg::mpp_tosel_t toSel;
  mpp_pkg::mpp_tosel_t next_toSel;
  logic [7:0] anSel;
  logic [7:0] next_anSel;
  logic stopMode;
  logic next_stopMode;
  logic subStop;
  logic next_subStop;

  // per-port registers and pin drivers
  for (genvar p = 0; p < NP; p++) begin : g_port
    logic [7:0] data;
    logic [7:0] next_data;
    logic [7:0] dir;
    logic [7:0] next_dir;
    logic [1:0] pull;
    logic [1:0] next_pull;
    logic [7:0] pinOut;
    logic [7:0] next_pinOut;
    logic [7:0] pinOeN;
    logic [7:0] next_pinOeN;
    logic [7:0] pullEn;
    logic [7:0] next_pullEn;
    logic hit;

    assign hit = wrFire && isPortArea && (portIdx == 3'(p));

    always_comb begin
      next_data = data;
      next_dir = dir;
      next_pull = pull;
      if (hit && regOfs == mpp_pkg::OFS_DATA) begin
        next_data = wb_dat_i[7:0];
      end
      if (hit && regOfs == mpp_pkg::OFS_DIR) begin
        next_dir = wb_dat_i[7:0];
      end
      if (hit && regOfs == mpp_pkg::OFS_PULL) begin
        next_pull = wb_dat_i[1:0];
      end
      next_pinOut = data;
      next_pinOeN = ~dir;
      if (p == mpp_pkg::PORT_B_IDX) begin
        if (sckSel[0]) begin
          next_pinOut[mpp_pkg::SERIAL_CLOCK_PIN_CH0_PIN] = serialSckOut[0];
          next_pinOeN[mpp_pkg::SERIAL_CLOCK_PIN_CH0_PIN] = ~(dir[mpp_pkg::SERIAL_CLOCK_PIN_CH0_PIN] | serialSckOe[0]);
        end
        if (soSel[0]) begin
          next_pinOut[mpp_pkg::SO0_PIN] = serialDataOut[0];
          next_pinOeN[mpp_pkg::SO0_PIN] = ~(dir[mpp_pkg::SO0_PIN] | serialDataOe[0]);
        end
        if (sckSel[1]) begin
          next_pinOut[mpp_pkg::SCK1_PIN] = serialSckOut[1];
          next_pinOeN[mpp_pkg::SCK1_PIN] = ~(dir[mpp_pkg::SCK1_PIN] | serialSckOe[1]);
        end
        if (soSel[1]) begin
          next_pinOut[mpp_pkg::SO1_PIN] = serialDataOut[1];
          next_pinOeN[mpp_pkg::SO1_PIN] = ~(dir[mpp_pkg::SO1_PIN] | serialDataOe[1]);
        end
      end
      // no pull-up on a pin driven by the latch or a serial channel
      next_pullEn = {{4{pull[1]}}, {4{pull[0]}}} & next_pinOeN;
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        data <= mpp_pkg::DATA_RST;
        dir <= mpp_pkg::DIR_RST;
        pull <= mpp_pkg::PULL_RST;
        pinOut <= mpp_pkg::DATA_RST;
        pinOeN <= ~mpp_pkg::DIR_RST;
        pullEn <= 8'h00;
      end else begin
        data <= next_data;
        dir <= next_dir;
        pull <= next_pull;
        pinOut <= next_pinOut;
        pinOeN <= next_pinOeN;
        pullEn <= next_pullEn;
      end
    end

    assign portDataW[p] = data;
    assign portDirW[p] = dir;
    assign portPullW[p] = pull;
    assign portPinOut[p] = pinOut;
    assign portPinOeN[p] = pinOeN;
    assign portPullEn[p] = pullEn;
  end

  // clock-adjust divider and timer square wave
  logic subPrev;
  logic next_subPrev;
  logic [mpp_pkg::ADJ_CNT_W-1:0] adjCnt;
  logic [mpp_pkg::ADJ_CNT_W-1:0] next_adjCnt;
  logic subTick;
  logic next_subTick;
  logic toWave;
  logic next_toWave;
  logic subRise;

  assign subRise = subLevel & ~subPrev;

  always_comb begin
    next_subPrev = subLevel;
    next_subTick = subRise & ~subStop;
    next_adjCnt = adjCnt;
    next_toWave = toWave;
    if (subRise && !subStop) begin
      next_adjCnt = adjCnt + 1'b1;
    end
    if (timerMatch) begin
      next_toWave = ~toWave;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      subPrev <= 1'b0;
      adjCnt <= '0;
      subTick <= 1'b0;
      toWave <= 1'b0;
    end else begin
      subPrev <= next_subPrev;
      adjCnt <= next_adjCnt;
      subTick <= next_subTick;
      toWave <= next_toWave;
    end
  end

  assign subclockTick = subTick;
  assign clockAdjustFast = adjCnt[mpp_pkg::ADJ_FAST_BIT];
  assign clockAdjustSlow = adjCnt[mpp_pkg::ADJ_SLOW_BIT];

  // port E, selections, analog select and oscillator control
  logic pwmPin;
  logic next_pwmPin;
  logic toPin;
  logic next_toPin;

  always_comb begin
    next_portEData = portEData;
    next_portEPull = portEPull;
    next_sckSel = sckSel;
    next_soSel = soSel;
    next_pwmSel = pwmSel;
    next_toSel = toSel;
    next_anSel = anSel;
    next_stopMode = stopMode;
    next_subStop = subStop;
    if (wrFire) begin
      case (wb_adr_i)
        mpp_pkg::ADDR_PORTE_DATA: next_portEData = wb_dat_i[5:4];
        mpp_pkg::ADDR_PORTE_PULL: next_portEPull = wb_dat_i[0];
        mpp_pkg::ADDR_OUT_SEL: begin
          next_sckSel = {wb_dat_i[mpp_pkg::SEL_SCK1_BIT], wb_dat_i[mpp_pkg::SEL_SERIAL_CLOCK_PIN_CH0_BIT]};
          next_soSel = {wb_dat_i[mpp_pkg::SEL_SO1_BIT], wb_dat_i[mpp_pkg::SEL_SO0_BIT]};
          next_pwmSel = wb_dat_i[mpp_pkg::SEL_PWM_BIT];
          next_toSel = mpp_pkg::mpp_tosel_t'(wb_dat_i[mpp_pkg::SEL_TO_LSB +: 2]);
        end
        mpp_pkg::ADDR_AN_SEL: next_anSel = wb_dat_i[7:0];
        mpp_pkg::ADDR_OSC_CTRL: begin
          next_stopMode = wb_dat_i[mpp_pkg::OSC_STOP_BIT];
          next_subStop = wb_dat_i[mpp_pkg::OSC_SUBSTOP_BIT];
        end
        default: ;
      endcase
    end
    if (stopExitReq) begin
      next_stopMode = 1'b0;
    end
    next_pwmPin = pwmSel ? pwmIn : portEData[0];
    case (toSel)
      mpp_pkg::MPP_TO_TIMER: next_toPin = toWave;
      mpp_pkg::MPP_TO_ADJ_FAST: next_toPin = clockAdjustFast;
      mpp_pkg::MPP_TO_ADJ_SLOW: next_toPin = clockAdjustSlow;
      default: next_toPin = portEData[1];
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      portEData <= mpp_pkg::PORTE_OUT_RST;
      portEPull <= mpp_pkg::PORTE_PULL_RST;
      sckSel <= mpp_pkg::SERIAL_SEL_RST;
      soSel <= mpp_pkg::SERIAL_SEL_RST;
      pwmSel <= mpp_pkg::PWM_SEL_RST;
      toSel <= mpp_pkg::MPP_TO_PORT;
      anSel <= mpp_pkg::AN_SEL_RST;
      stopMode <= 1'b0;
      subStop <= 1'b0;
      pwmPin <= 1'b1;
      toPin <= 1'b1;
    end else begin
      portEData <= next_portEData;
      portEPull <= next_portEPull;
      sckSel <= next_sckSel;
      soSel <= next_soSel;
      pwmSel <= next_pwmSel;
      toSel <= next_toSel;
      anSel <= next_anSel;
      stopMode <= next_stopMode;
      subStop <= next_subStop;
      pwmPin <= next_pwmPin;
      toPin <= next_toPin;
    end
  end

  assign pwmPinOut = pwmPin;
  assign timerAdjPinOut = toPin;
  assign portEPullEn = portEPull;
  assign analogMuxSel = anSel;
  assign mainOscFeedbackEn = ~stopMode;
  assign mainCrystalOutHigh = stopMode;
  assign subOscFeedbackEn = ~subStop;
  assign subclockInPinOut = 1'b0;
  assign subclockInPinOeN = ~subStop;
  assign subclockOutHigh = subStop;

  // register readback
  always_comb begin
    rdMux = 32'h0000_0000;
    if (isPortArea) begin
      case (regOfs)
        mpp_pkg::OFS_DATA: rdMux[7:0] = (portDirW[portIdx] & portDataW[portIdx])
                                      | (~portDirW[portIdx] & portLevel[portIdx]);
        mpp_pkg::OFS_DIR: rdMux[7:0] = portDirW[portIdx];
        mpp_pkg::OFS_PULL: rdMux[1:0] = portPullW[portIdx];
        default: ;
      endcase
    end else begin
      case (wb_adr_i)
        mpp_pkg::ADDR_PORTE_DATA: rdMux[5:0] = {portEData, portELevel};
        mpp_pkg::ADDR_PORTE_PULL: rdMux[0] = portEPull;
        mpp_pkg::ADDR_OUT_SEL: rdMux[6:0] = {toSel, pwmSel, soSel[1], sckSel[1], soSel[0], sckSel[0]};
        mpp_pkg::ADDR_AN_SEL: rdMux[7:0] = anSel;
        mpp_pkg::ADDR_OSC_CTRL: rdMux[1:0] = {subStop, stopMode};
        mpp_pkg::ADDR_STATUS: rdMux[3:0] = {clockAdjustSlow, clockAdjustFast, toWave, subLevel};
        default: ;
      endcase
    end
  end

  // single-cycle wait: ack one edge after the request, dropped the next
  always_comb begin
    next_ack = req & ~ack;
    next_rdData = (req & ~ack & ~wb_we_i) ? rdMux : 32'h0000_0000;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      rdData <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      rdData <= next_rdData;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdData;
endmodule

// ===== testbench/mpp_pins_monitor.sv
// concurrent checks on the port pin block ports
`timescale 1ns/1ps
module mpp_pins_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0][7:0] portPinIn,
  input wire logic [7:0][7:0] portPinOeN,
  input wire logic [7:0][7:0] portPullEn,
  input wire logic pwmPinOut,
  input wire logic timerAdjPinOut,
  input wire logic [7:0] analogMuxSel,
  input wire logic [3:0] extIrqLevel,
  input wire logic stopExitReq,
  input wire logic mainOscFeedbackEn,
  input wire logic mainCrystalOutHigh,
  input wire logic subclockInPinOut,
  input wire logic subclockInPinOeN,
  input wire logic subclockOutHigh,
  input wire logic subOscFeedbackEn,
  input wire logic subclockTick,
  input wire logic clockAdjustFast,
  input wire logic clockAdjustSlow
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_busAck;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_busAck: assert property (p_busAck) else $error("ack not a single pulse");
  property p_pullInput;
    (portPullEn & ~portPinOeN) == '0;
  endproperty
  a_pullInput: assert property (p_pullInput) else $error("pull-up on a driven pin");
  property p_resetState;
    $fell(rst) |-> &portPinOeN && portPullEn == '0 && analogMuxSel == 8'h00;
  endproperty
  a_resetState: assert property (p_resetState) else $error("pins not idle after reset");
  property p_fixedHigh;
    $fell(rst) |-> pwmPinOut && timerAdjPinOut;
  endproperty
  a_fixedHigh: assert property (p_fixedHigh) else $error("fixed outputs not high");
  property p_mainStop;
    mainCrystalOutHigh == !mainOscFeedbackEn;
  endproperty
  a_mainStop: assert property (p_mainStop) else $error("crystal pin and feedback disagree");
  property p_stopExit;
    stopExitReq |=> !mainCrystalOutHigh && mainOscFeedbackEn;
  endproperty
  a_stopExit: assert property (p_stopExit) else $error("stop not left on exit request");
  property p_subStop;
    subclockOutHigh |-> !subOscFeedbackEn && !subclockInPinOeN && !subclockInPinOut && !subclockTick;
  endproperty
  a_subStop: assert property (p_subStop) else $error("stopped subclock pins wrong");
  property p_irqLevel;
    !$past(rst) && !$past(rst, 2) |-> extIrqLevel == $past(portPinIn[7][3:0], 2);
  endproperty
  a_irqLevel: assert property (p_irqLevel) else $error("irq level not following pins");
  property p_adjust;
    ((clockAdjustFast != $past(clockAdjustFast)) == subclockTick) &&
    (!$rose(clockAdjustSlow) || (!clockAdjustFast && subclockTick));
  endproperty
  a_adjust: assert property (p_adjust) else $error("adjust divider out of step");
endmodule
bind mpp_port_pins mpp_pins_monitor u_mpp_pins_monitor (.*);

// ===== testbench/mpp_board.sv
// board model: pin levels seen by the port inputs
`timescale 1ns/1ps
module mpp_board (
  input wire logic mclk,
  input wire logic [7:0][7:0] portPinOut,
  input wire logic [7:0][7:0] portPinOeN,
  input wire logic [7:0][7:0] portPullEn,
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  input wire logic subSrc,
  input wire logic subclockInPinOut,
  input wire logic subclockInPinOeN,
  output logic [7:0][7:0] portPinIn,
  output logic subclockInPinIn
);
  logic flt = 1'h0;
  // undriven pin wanders
  always @(posedge mclk) flt <= ~flt;
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      for (int i = 0; i < 8; i++) begin
        if (!portPinOeN[p][i]) portPinIn[p][i] = portPinOut[p][i];
        else if (extEn[i]) portPinIn[p][i] = extVal[i];
        else if (portPullEn[p][i]) portPinIn[p][i] = 1'h1;
        else portPinIn[p][i] = flt;
      end
    end
    subclockInPinIn = subclockInPinOeN ? subSrc : subclockInPinOut;
  end
endmodule

// ===== testbench/tb_mpp_port_pins.sv
// self-checking bench for the port pin block
`timescale 1ns/1ps
module tb_mpp_port_pins;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [7:0][7:0] portPinIn, portPinOut, portPinOeN, portPullEn;
  logic [3:0] portEPinIn = 4'ha, portELevel, extIrqLevel;
  logic [1:0] serialSckOut = 2'h3, serialSckOe = 2'h3, serialDataOut = 2'h3, serialDataOe = 2'h3;
  logic pwmIn = 1'h0, timerMatch = 1'h0, stopExitReq = 1'h0, subSrc = 1'h0, w;
  logic portEPullEn, pwmPinOut, timerAdjPinOut, mainOscFeedbackEn, mainCrystalOutHigh, subclockInPinIn;
  logic subclockInPinOut, subclockInPinOeN, subclockOutHigh, subOscFeedbackEn, subclockTick;
  logic clockAdjustFast, clockAdjustSlow;
  logic [7:0] portBLevel, analogMuxSel, e, extVal = 8'ha5, extEn = 8'hf0;
  int n_fail = 0, checked = 0, cyc = 0;
  always #5 mclk = ~mclk;
  mpp_port_pins u_mpp_port_pins (.*);
  mpp_board u_mpp_board (.*);
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task bus(input logic we, input logic [11:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    // an ack ends this wait; without one only the bench timeout does
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge mclk);
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // subclock pin edges, slow enough for the synchroniser
  task edges(input int n);
    repeat (n) begin
      subSrc <= 1'h1;
      tick(4);
      subSrc <= 1'h0;
      tick(4);
    end
  endtask
  task final_report;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    tick(8);
    rst <= 1'h0;
    tick(1);
    chk("oen", 32'h1, 32'(&portPinOeN));
    chk("fixed", 32'h3, {pwmPinOut, timerAdjPinOut});
    chk("epull", 32'h0, portEPullEn);
    for (int p = 0; p < 8; p++) begin
      bus(1'h0, 12'(16 * p + 4), 8'h00);
      chk("dir", 32'h0, q);
      bus(1'h1, 12'(16 * p + 4), 8'h5a);
      bus(1'h1, 12'(16 * p), 8'hc3);
      bus(1'h1, 12'(16 * p + 8), 8'h01);
      tick(3);
      e = (8'hc3 & 8'h5a) | (8'ha5 & ((extVal & extEn) | (8'h0f & ~extEn)));
      bus(1'h0, 12'(16 * p), 8'h00);
      chk("rd", {24'h0, e}, q);
      chk("oen", 32'ha5, portPinOeN[p]);
      chk("pull", 32'h05, portPullEn[p]);
    end
    chk("irq", {28'h0, e[3:0]}, extIrqLevel);
    chk("blevel", {24'h0, e}, portBLevel);
    chk("elevel", 32'ha, portELevel);
    bus(1'h1, 12'h084, 8'h01);
    tick(1);
    chk("epull", 32'h1, portEPullEn);
    bus(1'h1, 12'h080, 8'h10);
    tick(2);
    bus(1'h0, 12'h080, 8'h00);
    chk("porte", 32'h1a, q);
    chk("fixed", 32'h2, {pwmPinOut, timerAdjPinOut});
    chk("serial", 32'h0, {portPinOut[1][4], portPinOut[1][2]});
    bus(1'h1, 12'h090, 8'h03);
    tick(2);
    chk("serial", 32'h3, {portPinOut[1][4], portPinOut[1][2]});
    // channel 1 outputs and the pwm source differ from their latches
    serialDataOut <= 2'h1;
    bus(1'h1, 12'h090, 8'h1f);
    tick(2);
    chk("serial1", 32'h2, {portPinOut[1][7], portPinOut[1][5], pwmPinOut});
    bus(1'h1, 12'h090, 8'h20);
    repeat (2) begin
      tick(2);
      w = timerAdjPinOut;
      timerMatch <= 1'h1;
      tick(1);
      timerMatch <= 1'h0;
      tick(2);
      chk("wave", {31'h0, ~w}, timerAdjPinOut);
    end
    edges(5);
    bus(1'h1, 12'h090, 8'h40);
    tick(2);
    chk("fast", 32'h1, timerAdjPinOut);
    bus(1'h1, 12'h090, 8'h60);
    tick(2);
    chk("slow", 32'h0, timerAdjPinOut);
    edges(6);
    chk("slow", 32'h1, timerAdjPinOut);
    bus(1'h1, 12'h090, 8'h00);
    tick(2);
    chk("port", 32'h0, timerAdjPinOut);
    bus(1'h1, 12'h094, 8'ha5);
    tick(1);
    chk("analog", 32'ha5, analogMuxSel);
    bus(1'h1, 12'h098, 8'h01);
    tick(1);
    chk("stop", 32'h2, {mainCrystalOutHigh, mainOscFeedbackEn});
    stopExitReq <= 1'h1;
    tick(1);
    stopExitReq <= 1'h0;
    tick(1);
    bus(1'h0, 12'h098, 8'h00);
    chk("exit", 32'h0, q);
    bus(1'h1, 12'h098, 8'h02);
    tick(2);
    chk("substop", 32'h4, {subclockOutHigh, subOscFeedbackEn, subclockInPinOeN});
    edges(3);
    bus(1'h0, 12'h09c, 8'h00);
    chk("status", 32'h6, {q[3:2], q[0]});
    bus(1'h0, 12'hffc, 8'h00);
    chk("unmapped", 32'h0, q);
    rst <= 1'h1;
    tick(2);
    chk("oen", 32'h1, 32'(&portPinOeN));
    chk("analog", 32'h0, analogMuxSel);
    rst <= 1'h0;
    tick(2);
    final_report();
  end
endmodule
